/* spf_pkg.sv */
// Purpose: Shared constants and types of the serial slave framing block
// Assumes: One 200 MHz clock; serial pins sampled as synchronous inputs
// Notes:   Header bit positions are fixed here and may be moved as one
package spf_pkg;

  localparam int unsigned BURST_W      = 8;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned HDR_RW_BIT   = 7;
  localparam int unsigned HDR_ADDR_MSB = 5;
  localparam int unsigned MIN_BURSTS   = 3;
  localparam int unsigned MIN_PAYLOAD  = 2;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned BYTE_CNT_W   = 8;

  localparam logic [2:0]         BIT_LAST    = 3'h7;
  localparam logic [2:0]         BIT_RST     = 3'h0;
  localparam logic [BURST_W-1:0] BYTE_RST    = 8'h00;
  localparam logic               MISO_RST    = 1'b0;

  typedef logic [BURST_W-1:0] spf_byte_t;
  typedef logic [ADDR_W-1:0]  spf_addr_t;

  typedef enum logic [4:0] {
    ST_OFF  = 5'h01,
    ST_IDLE = 5'h02,
    ST_HDR  = 5'h04,
    ST_WR   = 5'h08,
    ST_RD   = 5'h10
  } spf_state_e;

endpackage

/* spf_stream_if.sv */
// Purpose: Valid/ready byte stream between the framing logic and its FIFO
// Assumes: Transfer on a clock edge where valid and ready are both high
// Notes:   Width is a parameter
`timescale 1ns/1ps
`default_nettype none
interface spf_stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* spf_edge.sv */
// Purpose: Edge detector for a synchronous pin level
// Assumes: Input already synchronous to clk_i
// Notes:   Pulses last one cycle, in the cycle the new level is seen
`timescale 1ns/1ps
`default_nettype none
module spf_edge #(
  parameter logic IDLE_LVL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Level and edges
  input  wire logic sig_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_reg <= IDLE_LVL;
    end else begin
      prev_reg <= sig_i;
    end
  end

  assign rise_o = sig_i & ~prev_reg;
  assign fall_o = ~sig_i & prev_reg;
endmodule
`default_nettype wire

/* spf_fifo.sv */
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Ready on the fill side drops honestly when full
`timescale 1ns/1ps
`default_nettype none
module spf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Streams
  spf_stream_if.snk in_if,
  spf_stream_if.src out_if
);
  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("spf_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_if.ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_if.valid = (cnt_reg != '0);
  assign out_if.data  = mem_reg[rd_ptr_reg];
  assign push         = in_if.valid & in_if.ready;
  assign pop          = out_if.valid & out_if.ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_if.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      case ({push, pop})
        2'b10:   cnt_reg <= cnt_reg + (PW+1)'(1);
        2'b01:   cnt_reg <= cnt_reg - (PW+1)'(1);
        default: cnt_reg <= cnt_reg;
      endcase
    end
  end
endmodule
`default_nettype wire

/* spf_slave.sv */
// Purpose: Serial slave port framing: header decode, one-way payload, pin alternates
// Assumes: Serial clock far slower than clk_i; all pins synchronous to clk_i
// Notes:   Write payload leaves through a FIFO; read bytes are fetched per burst
//
// Summary of operation
// R1: Chip select falling low starts a new framed transaction.
// R2: A good frame holds at least three 8-bit bursts.
// R3: First burst is the header on the host-out line: address and direction.
// R4: Write moves payload host to device; read moves it device to host.
// R5: Payload bursts are host-out write data or device-driven read data.
// R6: Only one data line is meaningful in any burst.
// R7: Payload holds at least two bytes.
// R8: Payload byte count is always even; checked only up to 254 bytes, since the burst count saturates at 255.
// R9: Chip select returning high ends the transaction.
// R10: Alternate enable makes pin 2 show checksum-valid.
// R11: Alternate enable makes pin 1 show out-of-idle.
// R12: Active-low reset held low keeps the port off and clears it.
// R13: Reset released enters idle with all port registers at default.
// R14: Bursts shift most significant bit first on both lines.
// R15: Sample on rising serial clock edge, change output on falling edge.
// R16: Direction and address come from fixed header bit positions.
`timescale 1ns/1ps
`default_nettype none
module spf_slave #(
  parameter int unsigned DEPTH = spf_pkg::FIFO_DEPTH,
  parameter int unsigned CNT_W = spf_pkg::BYTE_CNT_W
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 rst_n_i,
  // Serial port
  input  wire logic                 serial_clock_in_i,
  input  wire logic                 chip_sel_n_i,
  input  wire logic                 mosi_i,
  output logic                      miso_o,
  output logic                      miso_oe_o,
  // Header
  output logic                      hdr_valid_o,
  output spf_pkg::spf_addr_t        addr_o,
  output logic                      is_read_o,
  // Write payload stream
  output logic                      wr_valid_o,
  output spf_pkg::spf_byte_t        wr_data_o,
  input  wire logic                 wr_ready_i,
  output logic                      overrun_o,
  // Read payload source
  output logic                      rd_req_o,
  input  wire spf_pkg::spf_byte_t   rd_data_i,
  // Frame status
  output logic                      frame_done_o,
  output logic                      frame_ok_o,
  output logic                      device_off_o,
  // Alternate pin control and sources
  input  wire logic                 gpio_alt_en_i,
  input  wire logic                 crc_valid_i,
  input  wire logic                 radio_busy_i,
  // Checksum-valid pin
  input  wire logic                 crc_valid_pin_i,
  output logic                      crc_valid_pin_o,
  output logic                      crc_valid_pin_oe_o,
  input  wire logic                 crc_valid_pin_dout_i,
  input  wire logic                 crc_valid_pin_den_i,
  output logic                      crc_valid_pin_din_o,
  // Out-of-idle pin
  input  wire logic                 out_of_idle_pin_i,
  output logic                      out_of_idle_pin_o,
  output logic                      out_of_idle_pin_oe_o,
  input  wire logic                 out_of_idle_pin_dout_i,
  input  wire logic                 out_of_idle_pin_den_i,
  output logic                      out_of_idle_pin_din_o
);
  import spf_pkg::*;

  if (CNT_W < 2 || DEPTH < 2) begin : g_bad_param
    $error("spf_slave: CNT_W and DEPTH must be at least 2");
  end

  spf_state_e       state_reg;
  spf_state_e       state_next;
  logic             off;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             cs_rise;
  logic             cs_fall;
  logic             in_frame;
  logic             byte_done;
  logic [2:0]       bit_cnt_reg;
  logic [CNT_W-1:0] byte_cnt_reg;
  spf_byte_t        rx_shift_reg;
  spf_byte_t        rx_next;
  spf_byte_t        tx_shift_reg;
  logic             miso_reg;
  logic             hdr_valid_reg;
  spf_addr_t        addr_reg;
  logic             is_read_reg;
  logic             frame_done_reg;
  logic             frame_ok_reg;
  logic             overrun_reg;
  logic             alt_out1_reg;
  logic             alt_oe1_reg;
  logic             alt_out2_reg;
  logic             alt_oe2_reg;
  logic             din1_reg;
  logic             din2_reg;

  spf_stream_if #(.WIDTH(BURST_W)) push_if ();
  spf_stream_if #(.WIDTH(BURST_W)) pop_if ();

  function automatic logic frame_good(input logic [CNT_W-1:0] n, input logic [2:0] b);
    frame_good = (b == BIT_RST) && (n >= CNT_W'(MIN_BURSTS)) && n[0]; // R2 R7 R8
  endfunction

  // Off while either reset is active
  assign off = srst_i | ~rst_n_i; // R12

  spf_edge #(.IDLE_LVL(1'b0)) u_sclk_edge (
    .clk_i  (clk_i),
    .srst_i (off),
    .sig_i  (serial_clock_in_i),
    .rise_o (sclk_rise),
    .fall_o (sclk_fall)
  );

  spf_edge #(.IDLE_LVL(1'b1)) u_cs_edge (
    .clk_i  (clk_i),
    .srst_i (off),
    .sig_i  (chip_sel_n_i),
    .rise_o (cs_rise),
    .fall_o (cs_fall)
  );

  assign in_frame  = (state_reg == ST_HDR) || (state_reg == ST_WR) || (state_reg == ST_RD);
  assign byte_done = in_frame && !chip_sel_n_i && sclk_rise && (bit_cnt_reg == BIT_LAST);
  assign rx_next   = {rx_shift_reg[BURST_W-2:0], mosi_i}; // R14

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        state_next = ST_IDLE; // R13
      end
      ST_IDLE: begin
        if (cs_fall) begin
          state_next = ST_HDR; // R1
        end
      end
      ST_HDR: begin
        if (cs_rise) begin
          state_next = ST_IDLE;
        end else if (byte_done) begin
          state_next = rx_next[HDR_RW_BIT] ? ST_RD : ST_WR; // R3 R4 R16
        end
      end
      ST_WR, ST_RD: begin
        if (cs_rise) begin
          state_next = ST_IDLE; // R9
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (off) begin
      state_reg <= ST_OFF; // R12
    end else begin
      state_reg <= state_next;
    end
  end

  // Bit and burst counters, restarted at each frame start
  always_ff @(posedge clk_i) begin
    if (off || cs_fall) begin
      bit_cnt_reg  <= BIT_RST;
      byte_cnt_reg <= '0;
    end else if (in_frame && !chip_sel_n_i && sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done && byte_cnt_reg != '1) begin
        byte_cnt_reg <= byte_cnt_reg + CNT_W'(1);
      end
    end
  end

  // Host-out sampling on rising edges only
  always_ff @(posedge clk_i) begin
    if (off) begin
      rx_shift_reg <= BYTE_RST;
    end else if ((state_reg == ST_HDR || state_reg == ST_WR) && sclk_rise) begin
      rx_shift_reg <= rx_next; // R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (off) begin
      hdr_valid_reg <= 1'b0;
      addr_reg      <= '0;
      is_read_reg   <= 1'b0;
    end else begin
      hdr_valid_reg <= (state_reg == ST_HDR) && byte_done && !cs_rise;
      if ((state_reg == ST_HDR) && byte_done) begin
        addr_reg    <= rx_next[HDR_ADDR_MSB -: ADDR_W]; // R16
        is_read_reg <= rx_next[HDR_RW_BIT];
      end
    end
  end

  // Write payload into the FIFO; host-out ignored during reads
  assign push_if.valid = (state_reg == ST_WR) && byte_done; // R5 R6
  assign push_if.data  = rx_next;

  always_ff @(posedge clk_i) begin
    if (off) begin
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= push_if.valid && !push_if.ready;
    end
  end

  // Read bytes fetched at each burst boundary
  assign rd_req_o = byte_done && !cs_rise &&
                    ((state_reg == ST_HDR && rx_next[HDR_RW_BIT]) || state_reg == ST_RD); // R4

  always_ff @(posedge clk_i) begin
    if (off || state_next == ST_IDLE) begin
      tx_shift_reg <= BYTE_RST;
      miso_reg     <= MISO_RST;
    end else if (rd_req_o) begin
      tx_shift_reg <= rd_data_i;
    end else if (state_reg == ST_RD && sclk_fall) begin
      miso_reg     <= tx_shift_reg[BURST_W-1]; // R14 R15
      tx_shift_reg <= {tx_shift_reg[BURST_W-2:0], 1'b0};
    end
  end

  assign miso_o    = miso_reg;
  assign miso_oe_o = (state_reg == ST_RD); // R5 R6

  // Frame check at chip select release
  always_ff @(posedge clk_i) begin
    if (off) begin
      frame_done_reg <= 1'b0;
      frame_ok_reg   <= 1'b0;
    end else begin
      frame_done_reg <= in_frame && cs_rise; // R9
      if (in_frame && cs_rise) begin
        frame_ok_reg <= frame_good(byte_cnt_reg, bit_cnt_reg); // R2 R7 R8
      end
    end
  end

  // Pin alternates; outputs float while off
  always_ff @(posedge clk_i) begin
    if (off) begin
      alt_out2_reg <= 1'b0;
      alt_oe2_reg  <= 1'b0;
      alt_out1_reg <= 1'b0;
      alt_oe1_reg  <= 1'b0;
      din1_reg     <= 1'b0;
      din2_reg     <= 1'b0;
    end else begin
      alt_out2_reg <= gpio_alt_en_i ? crc_valid_i : crc_valid_pin_dout_i; // R10
      alt_oe2_reg  <= gpio_alt_en_i | crc_valid_pin_den_i;
      alt_out1_reg <= gpio_alt_en_i ? radio_busy_i : out_of_idle_pin_dout_i; // R11
      alt_oe1_reg  <= gpio_alt_en_i | out_of_idle_pin_den_i;
      din1_reg     <= out_of_idle_pin_i;
      din2_reg     <= crc_valid_pin_i;
    end
  end

  spf_fifo #(.WIDTH(BURST_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i  (clk_i),
    .srst_i (off),
    .in_if  (push_if),
    .out_if (pop_if)
  );

  assign wr_valid_o            = pop_if.valid;
  assign wr_data_o             = pop_if.data;
  assign pop_if.ready          = wr_ready_i;
  assign overrun_o             = overrun_reg;
  assign hdr_valid_o           = hdr_valid_reg;
  assign addr_o                = addr_reg;
  assign is_read_o             = is_read_reg;
  assign frame_done_o          = frame_done_reg;
  assign frame_ok_o            = frame_ok_reg;
  assign device_off_o          = (state_reg == ST_OFF);
  assign crc_valid_pin_o       = alt_out2_reg;
  assign crc_valid_pin_oe_o    = alt_oe2_reg;
  assign crc_valid_pin_din_o   = din2_reg;
  assign out_of_idle_pin_o     = alt_out1_reg;
  assign out_of_idle_pin_oe_o  = alt_oe1_reg;
  assign out_of_idle_pin_din_o = din1_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_cs_start;
    (state_reg == ST_IDLE) && cs_fall && rst_n_i |=> (state_reg == ST_HDR);
  endproperty
  a_cs_start: assert property (p_cs_start) else $error("frame start missed"); // R1

  property p_cs_end;
    in_frame && cs_rise && rst_n_i |=> (state_reg == ST_IDLE) && frame_done_o;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("frame end missed"); // R9

  property p_one_line;
    (state_reg == ST_WR) || push_if.valid |-> !miso_oe_o && !rd_req_o && !is_read_o;
  endproperty
  a_one_line: assert property (p_one_line) else $error("both lines active"); // R6

  property p_hdr_dir;
    hdr_valid_o |-> (state_reg == (is_read_o ? ST_RD : ST_WR));
  endproperty
  a_hdr_dir: assert property (p_hdr_dir) else $error("header direction wrong"); // R3

  property p_frame_ok;
    frame_done_o && frame_ok_o |-> ($past(byte_cnt_reg) >= CNT_W'(MIN_BURSTS)) &&
                                   $past(byte_cnt_reg[0]);
  endproperty
  a_frame_ok: assert property (p_frame_ok) else $error("bad frame accepted"); // R8

  property p_miso_fall;
    (state_reg == ST_RD) && $past(state_reg == ST_RD) && $changed(miso_o) |->
      $past(sclk_fall);
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("output changed off edge"); // R15

  property p_off;
    !rst_n_i |=> (state_reg == ST_OFF) && !miso_oe_o && !crc_valid_pin_oe_o ##1 !wr_valid_o;
  endproperty
  a_off: assert property (p_off) else $error("not off under reset"); // R12

  property p_wake;
    !rst_n_i ##1 rst_n_i |=> (state_reg == ST_IDLE) && !hdr_valid_o && !is_read_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no idle after reset"); // R13

  property p_alt2;
    rst_n_i && gpio_alt_en_i |=> crc_valid_pin_oe_o && (crc_valid_pin_o == $past(crc_valid_i));
  endproperty
  a_alt2: assert property (p_alt2) else $error("checksum pin wrong"); // R10

  property p_alt1;
    rst_n_i && gpio_alt_en_i |=> out_of_idle_pin_oe_o &&
                                 (out_of_idle_pin_o == $past(radio_busy_i));
  endproperty
  a_alt1: assert property (p_alt1) else $error("idle pin wrong"); // R11
endmodule
`default_nettype wire

/* spf_host_model.sv */
// Purpose: Host serial master model driving clock, chip select and host-out data
// Assumes: Serial clock idles low, each level held HALF system clocks
// Notes:   Host-out line is toggled when deselected so no stale bit lingers
`timescale 1ns/1ps
`default_nettype none
module spf_host_model
  import spf_pkg::*;
#(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic clk_i,
  // Serial lines
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Frame open and close
  task automatic select(input logic on);
    wait_clk(HALF);
    cs_n_o = ~on;
    if (!on) begin
      mosi_o = ~mosi_o;
    end
    wait_clk(HALF);
  endtask

  // One burst, possibly cut short
  task automatic burst(input spf_byte_t tx, input int nbits, output spf_byte_t rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[7-i];
      wait_clk(HALF);
      sclk_o = 1'b1;
      rx[7-i] = miso_i;
      wait_clk(HALF);
      sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* spf_slave_bench.sv */
// Purpose: Self-checking bench of the serial slave framing block
// Assumes: Host model drives the serial lines; bench plays the data sinks
// Notes:   Payload length and last-burst bits vary to hit good and bad frames
`timescale 1ns/1ps
`default_nettype none
module spf_slave_bench;
  import spf_pkg::*;
  logic      clk_i, srst_i, rst_n_i, sclk, cs_n, mosi, miso, miso_oe;
  logic      hdr_valid, is_read, wr_valid, wr_ready, overrun, rd_req;
  logic      frame_done, frame_ok, device_off, alt_en, crc_src, busy_src;
  logic      c_out, c_oe, c_dout, c_den, c_din, o_out, o_oe, o_din, ext_lvl;
  spf_addr_t addr;
  spf_byte_t wr_data, rd_data, rd_cnt, hdr_addr_q;
  logic      hdr_rd_q, oe_seen;
  int        errors, compares, done_cnt, ovr_cnt, cyc;
  spf_byte_t wq[$], rq[$];

  assign rd_data = 8'h5a + rd_cnt * 8'h11;

  spf_host_model i_host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
                         .mosi_o(mosi));

  spf_slave i_dut (.clk_i(clk_i), .srst_i(srst_i), .rst_n_i(rst_n_i),
    .serial_clock_in_i(sclk), .chip_sel_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_o(miso_oe), .hdr_valid_o(hdr_valid), .addr_o(addr), .is_read_o(is_read),
    .wr_valid_o(wr_valid), .wr_data_o(wr_data), .wr_ready_i(wr_ready), .overrun_o(overrun),
    .rd_req_o(rd_req), .rd_data_i(rd_data), .frame_done_o(frame_done), .frame_ok_o(frame_ok),
    .device_off_o(device_off), .gpio_alt_en_i(alt_en), .crc_valid_i(crc_src),
    .radio_busy_i(busy_src), .crc_valid_pin_i(c_oe ? c_out : ext_lvl),
    .crc_valid_pin_o(c_out), .crc_valid_pin_oe_o(c_oe), .crc_valid_pin_dout_i(c_dout),
    .crc_valid_pin_den_i(c_den), .crc_valid_pin_din_o(c_din),
    .out_of_idle_pin_i(o_oe ? o_out : ~ext_lvl), .out_of_idle_pin_o(o_out),
    .out_of_idle_pin_oe_o(o_oe), .out_of_idle_pin_dout_i(~c_dout),
    .out_of_idle_pin_den_i(c_den), .out_of_idle_pin_din_o(o_din));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Sinks and monitors
  always @(posedge clk_i) begin
    cyc++;
    if (wr_valid && wr_ready) wq.push_back(wr_data);
    if (overrun) ovr_cnt++;
    if (frame_done) done_cnt++;
    if (miso_oe) oe_seen = 1'b1;
    if (rd_req) rd_cnt <= rd_cnt + 8'h01;
    if (hdr_valid) begin
      hdr_addr_q <= {2'b00, addr};
      hdr_rd_q   <= is_read;
    end
    if (cyc == 20000) begin
      $display("MISMATCH timeout expected %0d seen %0d", 20000, cyc);
      errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input spf_byte_t exp, input spf_byte_t got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic spf_byte_t pb(input int k);
    return 8'(8'hc1 + 8'h3b * k);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Whole frame: header, n payload bursts, last one cut to last_bits
  task automatic frame(input spf_byte_t hdr, input int n, input int last_bits, input logic ok);
    spf_byte_t rx;
    int        d0;
    wq.delete();
    rq.delete();
    rd_cnt  = 8'h00;
    oe_seen = 1'b0;
    i_host.select(1'b1);
    i_host.burst(hdr, 8, rx);
    for (int k = 0; k < n; k++) begin
      i_host.burst(pb(k), (k == n - 1) ? last_bits : 8, rx);
      rq.push_back(rx);
    end
    d0 = done_cnt;
    i_host.select(1'b0);
    chk("frame_done", 8'h01, 8'(done_cnt - d0));
    chk("frame_ok", {7'h00, ok}, {7'h00, frame_ok});
    chk("hdr_addr", {2'b00, hdr[5:0]}, hdr_addr_q);
    chk("hdr_read", {7'h00, hdr[7]}, {7'h00, hdr_rd_q});
  endtask

  task automatic t_write;
    frame(8'h2a, 4, 8, 1'b1);
    step(4);
    chk("wr_count", 8'h04, 8'(wq.size()));
    for (int k = 0; k < 4; k++) chk("wr_data", pb(k), (k < wq.size()) ? wq[k] : 8'hxx);
    chk("oe_in_write", 8'h00, {7'h00, oe_seen});
  endtask

  task automatic t_read;
    frame(8'h95, 4, 8, 1'b1);
    for (int k = 0; k < 4; k++) chk("rd_data", 8'(8'h5a + 8'h11 * k), rq[k]);
    chk("oe_in_read", 8'h01, {7'h00, oe_seen});
    chk("wr_in_read", 8'h00, 8'(wq.size()));
  endtask

  // Short, odd and cut frames are flagged bad; a two-byte payload frame is flagged good
  task automatic t_bad;
    frame(8'h01, 1, 8, 1'b0);
    frame(8'h02, 3, 8, 1'b0);
    frame(8'h83, 2, 5, 1'b0);
    frame(8'h04, 0, 8, 1'b0);
    frame(8'h05, 2, 8, 1'b1);
  endtask

  // Fill with sink stalling, refuse, then drain
  task automatic t_fifo;
    wr_ready = 1'b0;
    ovr_cnt  = 0;
    frame(8'h10, 18, 8, 1'b1);
    chk("overruns", 8'h02, 8'(ovr_cnt));
    wr_ready = 1'b1;
    step(20);
    chk("drained", 8'h10, 8'(wq.size()));
    for (int k = 0; k < 16; k++) chk("fifo_data", pb(k), wq[k]);
    chk("empty", 8'h00, {7'h00, wr_valid});
  endtask

  // Off state via reset pin loses queued bytes and floats pins
  task automatic t_reset_pin;
    wr_ready = 1'b0;
    alt_en   = 1'b1;
    frame(8'h11, 2, 8, 1'b1);
    rst_n_i = 1'b0;
    step(3);
    chk("off", 8'h01, {7'h00, device_off});
    chk("oe_off", 8'h00, {5'h00, c_oe, o_oe, miso_oe});
    chk("wr_off", 8'h00, {7'h00, wr_valid});
    rst_n_i = 1'b1;
    step(3);
    chk("idle", 8'h00, {7'h00, device_off});
    wr_ready = 1'b1;
    step(2);
    chk("fifo_lost", 8'h00, {7'h00, wr_valid});
  endtask

  // Alternate pin sources against ordinary drive
  task automatic t_pins;
    logic eo, ee;
    for (int i = 0; i < 8; i++) begin
      alt_en   = i[2];
      crc_src  = i[0];
      busy_src = i[1];
      c_dout   = ~i[0];
      c_den    = i[1];
      ext_lvl  = i[0] ^ i[1];
      step(4);
      eo = i[2] ? i[0] : ~i[0];
      ee = i[2] | i[1];
      chk("crc_pin", {5'h00, eo, ee, ee ? eo : ext_lvl}, {5'h00, c_out, c_oe, c_din});
      eo = i[2] ? i[1] : i[0];
      chk("idle_pin", {5'h00, eo, ee, ee ? eo : ~ext_lvl}, {5'h00, o_out, o_oe, o_din});
    end
  endtask

  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    srst_i   = 1'b1;
    rst_n_i  = 1'b1;
    wr_ready = 1'b1;
    alt_en   = 1'b0;
    crc_src  = 1'b0;
    busy_src = 1'b0;
    c_dout   = 1'b0;
    c_den    = 1'b0;
    ext_lvl  = 1'b0;
    rd_cnt   = 8'h00;
    errors   = 0;
    compares = 0;
    done_cnt = 0;
    ovr_cnt  = 0;
    cyc      = 0;
    oe_seen  = 1'b0;
    step(10);
    chk("oe_rst", 8'h00, {5'h00, c_oe, o_oe, miso_oe});
    srst_i = 1'b0;
    step(3);
    chk("idle_rst", 8'h00, {7'h00, device_off});
    t_write();
    t_read();
    t_bad();
    t_fifo();
    t_reset_pin();
    t_pins();
    test_done();
  end
endmodule
`default_nettype wire
